/* iob_osc_block.sv */
// Internal oscillator control block with APB registers and pin reuse
`timescale 1ns/1ps
`include "iob_regs.svh"

module iob_osc_block #(
   parameter int SETTLE_CYCLES = `IOB_SETTLE_US * `IOB_PCLK_MHZ
) (
   // APB clock and reset
   input  wire logic                    pclk,
   input  wire logic                    presetn,
   // APB slave
   input  wire logic                    psel,
   input  wire logic                    penable,
   input  wire logic                    pwrite,
   input  wire logic [`IOB_ADDR_W-1:0]  paddr,
   input  wire logic [31:0]             pwdata,
   input  wire logic [3:0]              pstrb,
   output logic                         pready,
   output logic                         pslverr,
   output logic [31:0]                  prdata,
   // Configuration and control from elsewhere
   input  wire logic [3:0]              osc_config,
   input  wire logic [2:0]              internal_freq_select,
   input  wire logic                    pwrup_timer_en,
   input  wire logic                    failsafe_mon_en,
   input  wire logic                    watchdog_en,
   input  wire logic                    two_speed_en,
   input  wire logic                    instr_clk,
   // Port A logic
   input  wire logic                    port_a_bit6_out,
   input  wire logic                    port_a_bit6_oe,
   input  wire logic                    port_a_bit7_out,
   input  wire logic                    port_a_bit7_oe,
   output logic                         port_a_bit6_in,
   output logic                         port_a_bit7_in,
   // Oscillator pins
   input  wire logic                    osc_input_pin_in,
   output logic                         osc_input_pin_out,
   output logic                         osc_input_pin_oe,
   input  wire logic                    osc_output_pin_in,
   output logic                         osc_output_pin_out,
   output logic                         osc_output_pin_oe,
   // Oscillator controls
   output logic                         fast_internal_clock_en,
   output logic                         slow_rc_clock_en,
   output logic                         multiplier_active,
   output iob_pkg::iob_src_t            clk_source,
   output logic [3:0]                   postscale_shift,
   output logic signed [`IOB_TRIM_W-1:0] trim_offset,
   output logic                         trim_slewing
);

   iob_pkg::iob_state_t st_ff;
   iob_pkg::iob_state_t nxt_st;

   logic clkout_mode;
   logic dualio_mode;
   logic int_mode;
   logic mult_allowed;
   logic setup_ph;
   logic wr_take;
   logic wr_trim;
   logic [2:0] ifs;
   logic [31:0] trim_rd;
   logic [31:0] stat_rd;

   localparam logic [`IOB_SETTLE_W-1:0] SETTLE_LOAD =
      `IOB_SETTLE_W'(SETTLE_CYCLES);

   assign ifs         = internal_freq_select;
   assign clkout_mode = (osc_config == `IOB_CFG_CLKOUT);
   assign dualio_mode = (osc_config == `IOB_CFG_DUALIO);
   // Crystal multiplied config falls outside both codes
   assign int_mode    = clkout_mode | dualio_mode;
   assign mult_allowed = int_mode &
                         ((ifs == `IOB_IFS_8M) |
                          (ifs == `IOB_IFS_4M));

   assign setup_ph = psel & ~penable;
   assign wr_take  = psel & penable & st_ff.pready & pwrite;
   assign wr_trim  = wr_take & (paddr == `IOB_TRIM_ADDR) & pstrb[0];

   // Unimplemented bit 5 reads zero
   always_comb begin
      trim_rd = 32'h0000_0000;
      trim_rd[`IOB_LFSEL_BIT] = st_ff.lfsel;
      trim_rd[`IOB_MULT_BIT] = st_ff.mult;
      trim_rd[`IOB_TRIM_MSB:0] = st_ff.trim;
   end

   always_comb begin
      stat_rd = 32'h0000_0000;
      stat_rd[`IOB_ST_IFS_LSB +: 3] = ifs;
      stat_rd[`IOB_ST_SRC_LSB +: 3] = st_ff.src;
      stat_rd[`IOB_ST_FAST] = st_ff.fast_en;
      stat_rd[`IOB_ST_SLOW] = st_ff.slow_en;
      stat_rd[`IOB_ST_PLL] = st_ff.pll_on;
   end

   always_comb begin
      nxt_st = st_ff;

      // APB answer one cycle after setup
      nxt_st.pready = setup_ph;
      if (setup_ph) begin
         nxt_st.pslverr = 1'b0;
         if (paddr == `IOB_TRIM_ADDR) begin
            nxt_st.prdata = pwrite ? 32'h0000_0000 : trim_rd;
         end else if (paddr == `IOB_STAT_ADDR) begin
            nxt_st.prdata = pwrite ? 32'h0000_0000 : stat_rd;
         end else begin
            nxt_st.prdata = 32'h0000_0000;
            nxt_st.pslverr = 1'b1;
         end
      end else if (psel & penable & st_ff.pready) begin
         nxt_st.pslverr = 1'b0;
      end

      // Trim register fields
      if (wr_trim) begin
         nxt_st.lfsel = pwdata[`IOB_LFSEL_BIT];
         nxt_st.trim  = pwdata[`IOB_TRIM_MSB:0];
      end

      // Multiplier enable held clear when unavailable
      if (!mult_allowed) begin
         nxt_st.mult = 1'b0;
      end else if (wr_trim) begin
         nxt_st.mult = pwdata[`IOB_MULT_BIT];
      end

      // Frequency shift in progress; not visible to software
      if (wr_trim) begin
         nxt_st.settle = SETTLE_LOAD;
      end else if (st_ff.settle != '0) begin
         nxt_st.settle = st_ff.settle - `IOB_SETTLE_W'(1);
      end
      nxt_st.slewing = (nxt_st.settle != '0);

      // Oscillator enables
      nxt_st.fast_en = (ifs != `IOB_IFS_31K) |
                       nxt_st.lfsel;
      // Slow RC never looks at the trim value
      nxt_st.slow_en = ((ifs == `IOB_IFS_31K) & ~nxt_st.lfsel) |
                       pwrup_timer_en | failsafe_mon_en |
                       watchdog_en | two_speed_en;
      // Multiplier times four on 4 or 8 MHz
      nxt_st.pll_on = nxt_st.mult & mult_allowed;

      // Clock source and postscaler selection
      if (ifs == `IOB_IFS_8M) begin
         nxt_st.src   = iob_pkg::IOB_SRC_FAST;
         nxt_st.shift = 4'h0;
      end else if (ifs != `IOB_IFS_31K) begin
         nxt_st.src   = iob_pkg::IOB_SRC_POST;
         nxt_st.shift = 4'(`IOB_IFS_8M - ifs);
      end else if (nxt_st.lfsel) begin
         nxt_st.src   = iob_pkg::IOB_SRC_POST;
         nxt_st.shift = `IOB_LF_SHIFT;
      end else begin
         nxt_st.src   = iob_pkg::IOB_SRC_SLOW;
         nxt_st.shift = 4'h0;
      end

      // Pin input synchronisers and filters
      nxt_st.sync6 = {st_ff.sync6[1:0], osc_output_pin_in};
      nxt_st.sync7 = {st_ff.sync7[1:0], osc_input_pin_in};
      if (st_ff.sync6[1] == st_ff.sync6[2]) begin
         nxt_st.filt6 = st_ff.sync6[2];
      end
      if (st_ff.sync7[1] == st_ff.sync7[2]) begin
         nxt_st.filt7 = st_ff.sync7[2];
      end

      // Input pin as port bit 7 in both internal modes
      nxt_st.in_out   = int_mode & port_a_bit7_out;
      nxt_st.in_oe    = int_mode & port_a_bit7_oe;
      nxt_st.port7_in = int_mode & st_ff.filt7;

      // Output pin: instruction clock or port bit 6
      if (clkout_mode) begin
         nxt_st.out_out = instr_clk;
         nxt_st.out_oe  = 1'b1;
      end else if (dualio_mode) begin
         nxt_st.out_out = port_a_bit6_out;
         nxt_st.out_oe  = port_a_bit6_oe;
      end else begin
         nxt_st.out_out = 1'b0;
         nxt_st.out_oe  = 1'b0;
      end
      nxt_st.port6_in = dualio_mode & st_ff.filt6;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_ff        <= '0;
         st_ff.trim   <= `IOB_TRIM_RST;
         st_ff.src    <= iob_pkg::IOB_SRC_FAST;
         st_ff.fast_en <= 1'b1;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign pready  = st_ff.pready;
   assign pslverr = st_ff.pslverr;
   assign prdata  = st_ff.prdata;

   assign port_a_bit6_in     = st_ff.port6_in;
   assign port_a_bit7_in     = st_ff.port7_in;
   assign osc_input_pin_out  = st_ff.in_out;
   assign osc_input_pin_oe   = st_ff.in_oe;
   assign osc_output_pin_out = st_ff.out_out;
   assign osc_output_pin_oe  = st_ff.out_oe;

   assign fast_internal_clock_en = st_ff.fast_en;
   assign slow_rc_clock_en       = st_ff.slow_en;
   assign multiplier_active      = st_ff.pll_on;
   assign clk_source             = st_ff.src;
   assign postscale_shift        = st_ff.shift;
   // Zero is the calibrated centre, sign gives direction
   assign trim_offset  = $signed(st_ff.trim);
   assign trim_slewing = st_ff.slewing;

endmodule

/* iob_pkg.sv */
// Types shared by the oscillator block
`include "iob_regs.svh"

package iob_pkg;

   typedef enum logic [2:0] {
      IOB_SRC_FAST = 3'b001,
      IOB_SRC_POST = 3'b010,
      IOB_SRC_SLOW = 3'b100
   } iob_src_t;

   typedef struct packed {
      logic                     lfsel;
      logic                     mult;
      logic [`IOB_TRIM_W-1:0]   trim;
      logic [`IOB_SETTLE_W-1:0] settle;
      logic                     slewing;
      logic                     pready;
      logic                     pslverr;
      logic [31:0]              prdata;
      logic [2:0]               sync6;
      logic [2:0]               sync7;
      logic                     filt6;
      logic                     filt7;
      logic                     in_out;
      logic                     in_oe;
      logic                     out_out;
      logic                     out_oe;
      logic                     port6_in;
      logic                     port7_in;
      logic                     fast_en;
      logic                     slow_en;
      logic                     pll_on;
      iob_src_t                 src;
      logic [3:0]               shift;
   } iob_state_t;

endpackage

/* iob_props.sv */
// Port-level checker of the oscillator block
`timescale 1ns/1ps
`include "iob_regs.svh"
module iob_props (
   input wire logic pclk, presetn, psel, penable, pwrite, pready, pslverr,
   input wire logic pwrup_timer_en, failsafe_mon_en, watchdog_en,
   input wire logic two_speed_en, instr_clk, port_a_bit7_out,
   input wire logic osc_input_pin_out, osc_output_pin_out, osc_output_pin_oe,
   input wire logic fast_internal_clock_en, slow_rc_clock_en,
   input wire logic multiplier_active, trim_slewing,
   input wire logic [`IOB_ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata, prdata,
   input wire logic [3:0] pstrb, osc_config, postscale_shift,
   input wire logic [2:0] internal_freq_select,
   input wire logic [2:0] clk_source,
   input wire logic signed [`IOB_TRIM_W-1:0] trim_offset
);
   logic ok;
   assign ok = osc_config inside {`IOB_CFG_CLKOUT, `IOB_CFG_DUALIO}
               && &internal_freq_select[2:1];
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_trim_wr;
      psel && penable && pready && pwrite && paddr == `IOB_TRIM_ADDR
         && pstrb[0];
   endsequence
   property p_ready;
      s_setup |=> pready ##1 !pready;
   endproperty
   property p_err;
      pready && !(paddr inside {`IOB_TRIM_ADDR, `IOB_STAT_ADDR})
         |-> pslverr && prdata == 32'h0;
   endproperty
   property p_slew;
      s_trim_wr |=> trim_slewing && trim_offset == $past(pwdata[4:0]);
   endproperty
   property p_sup;
      pwrup_timer_en || failsafe_mon_en || watchdog_en || two_speed_en
         |=> slow_rc_clock_en;
   endproperty
   property p_fast;
      internal_freq_select != 3'h0 |=> fast_internal_clock_en;
   endproperty
   property p_shift;
      internal_freq_select != 3'h0
         |=> postscale_shift == 4'h7 - {1'b0, $past(internal_freq_select)};
   endproperty
   property p_mult;
      multiplier_active |-> $past(ok);
   endproperty
   property p_src;
      internal_freq_select == `IOB_IFS_8M |=> clk_source == 3'b001;
   endproperty
   property p_clkout;
      osc_config == `IOB_CFG_CLKOUT |=> osc_output_pin_oe
         && osc_output_pin_out == $past(instr_clk)
         && osc_input_pin_out == $past(port_a_bit7_out);
   endproperty
   a_ready: assert property (p_ready) else $error("pready timing");
   a_err: assert property (p_err) else $error("unmapped answer");
   a_slew: assert property (p_slew) else $error("trim write");
   a_sup: assert property (p_sup) else $error("slow rc off");
   a_fast: assert property (p_fast) else $error("fast osc off");
   a_shift: assert property (p_shift) else $error("postscale");
   a_mult: assert property (p_mult) else $error("multiplier on");
   a_clkout: assert property (p_clkout) else $error("clock out pin");
   a_src: assert property (p_src) else $error("clock source");
endmodule

bind iob_osc_block iob_props iob_props_inst (.*);

/* iob_regs.svh */
// Register map, field positions and timing constants of the oscillator block
`ifndef IOB_REGS_SVH
`define IOB_REGS_SVH

// APB byte addresses
`define IOB_ADDR_W     12
`define IOB_TRIM_ADDR  12'h000
`define IOB_STAT_ADDR  12'h004

// Trim register layout
`define IOB_LFSEL_BIT  7
`define IOB_MULT_BIT   6
`define IOB_TRIM_MSB   4
`define IOB_TRIM_W     5
`define IOB_TRIM_RST   5'h00
`define IOB_TRIM_CTR   5'h00

// Status register layout
`define IOB_ST_IFS_LSB 0
`define IOB_ST_SRC_LSB 3
`define IOB_ST_FAST    6
`define IOB_ST_SLOW    7
`define IOB_ST_PLL     8

// Primary oscillator configuration codes
`define IOB_CFG_CLKOUT 4'h9
`define IOB_CFG_DUALIO 4'h8
`define IOB_CFG_XTMULT 4'h6

// Frequency select codes
`define IOB_IFS_8M     3'h7
`define IOB_IFS_4M     3'h6
`define IOB_IFS_31K    3'h0

// Postscaler shift for the 31.25 kHz fast-derived clock, and multiplier factor
`define IOB_LF_SHIFT   4'h8
`define IOB_PLL_FACTOR 4

// Trim settling time
`define IOB_SETTLE_US  1000
`define IOB_PCLK_MHZ   25
`define IOB_SETTLE_W   15

`endif

/* tb_iob_osc_block.sv */
// Self-checking testbench of the oscillator block
`timescale 1ns/1ps
`include "iob_regs.svh"
module tb_iob_osc_block;
   localparam int SC = 8;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic ick = 0, pin1 = 0, pin2 = 0, pready, pslverr, p6i, p7i, ok, er;
   logic i_out, i_oe, o_out, o_oe, fen, sen, mact, slew;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, rd, d;
   logic [3:0] pstrb = 0, cfg = 0, sup = 0, po = 0, shf;
   logic [2:0] ifs = 0;
   logic signed [4:0] tof;
   iob_pkg::iob_src_t src;
   int fails = 0, checked = 0;
   always #20 pclk = ~pclk;
   always @(posedge pclk) ick <= ~ick;
   iob_osc_block #(.SETTLE_CYCLES(SC)) iob_osc_block_inst (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .pready(pready), .pslverr(pslverr), .prdata(prdata),
      .osc_config(cfg), .internal_freq_select(ifs), .pwrup_timer_en(sup[0]),
      .failsafe_mon_en(sup[1]), .watchdog_en(sup[2]), .two_speed_en(sup[3]),
      .instr_clk(ick), .port_a_bit6_out(po[0]), .port_a_bit6_oe(po[1]),
      .port_a_bit7_out(po[2]), .port_a_bit7_oe(po[3]),
      .port_a_bit6_in(p6i), .port_a_bit7_in(p7i),
      .osc_input_pin_in(pin1), .osc_input_pin_out(i_out),
      .osc_input_pin_oe(i_oe), .osc_output_pin_in(pin2),
      .osc_output_pin_out(o_out), .osc_output_pin_oe(o_oe),
      .fast_internal_clock_en(fen), .slow_rc_clock_en(sen),
      .multiplier_active(mact), .clk_source(src), .postscale_shift(shf),
      .trim_offset(tof), .trim_slewing(slew));
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         fails++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task stop_test;
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
            input logic [3:0] s);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      pstrb <= s;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   function automatic logic [2:0] e_src(logic [2:0] f, logic l);
      return f == 3'h7 ? 3'b001 : (f == 3'h0 && !l) ? 3'b100 : 3'b010;
   endfunction
   function automatic logic [3:0] e_shf(logic [2:0] f, logic l);
      return f != 3'h0 ? 4'h7 - {1'b0, f} : {l, 3'h0};
   endfunction
   initial begin
      void'($urandom(31528));
      repeat (10) @(posedge pclk);
      chk(src, 3'b001);
      presetn <= 1'b1;
      apb(1'b0, `IOB_TRIM_ADDR, 32'h0, 4'h0);
      chk(rd, 32'h0);
      chk($unsigned(tof), 5'h00);
      $display("test reset done");
      for (int i = 0; i < 32; i++) begin
         cfg <= i < 8 ? 4'h9 : i < 16 ? 4'h8 : i < 24 ? 4'h6 : 4'($urandom);
         ifs <= 3'(i);
         sup <= $urandom % 3 == 0 ? 4'($urandom) : 4'h0;
         d = $urandom;
         apb(1'b1, `IOB_TRIM_ADDR, d, 4'($urandom) | 4'h1);
         ok = (cfg == 4'h9 || cfg == 4'h8) && ifs[2:1] == 2'b11;
         apb(1'b0, `IOB_TRIM_ADDR, 32'h0, 4'h0);
         chk(rd, {24'h0, d[7], d[6] & ok, 1'b0, d[4:0]});
         chk($unsigned(tof), d[4:0]);
         chk(slew, 1'b1);
         chk(mact, d[6] & ok);
         apb(1'b0, `IOB_STAT_ADDR, 32'h0, 4'h0);
         chk(rd, {23'h0, d[6] & ok, (ifs == 3'h0 && !d[7]) || |sup,
             ifs != 3'h0 || d[7], e_src(ifs, d[7]),
             ifs});
         chk(shf, e_shf(ifs, d[7]));
         chk(src, e_src(ifs, d[7]));
      end
      $display("test trim and select done");
      cfg <= 4'h9;
      ifs <= 3'h6;
      apb(1'b1, `IOB_TRIM_ADDR, 32'h55, 4'h1);
      ifs <= 3'h5;
      repeat (SC + 4) @(posedge pclk);
      chk(slew, 1'b0);
      chk(mact, 1'b0);
      apb(1'b1, `IOB_TRIM_ADDR, 32'h0a, 4'h0);
      apb(1'b1, `IOB_STAT_ADDR, 32'h0, 4'hf);
      apb(1'b0, `IOB_TRIM_ADDR, 32'h0, 4'h0);
      chk(rd, 32'h15);
      chk(slew, 1'b0);
      apb(1'b1, 12'h008, 32'h0, 4'hf);
      chk(er, 1'b1);
      apb(1'b0, 12'hffc, 32'h0, 4'h0);
      chk(er, 1'b1);
      chk(rd, 32'h0);
      $display("test refusals done");
      for (int k = 0; k < 3; k++) begin
         cfg <= k == 0 ? 4'h9 : k == 1 ? 4'h8 : 4'h0;
         po <= 4'($urandom);
         pin1 <= 1'($urandom);
         pin2 <= 1'($urandom);
         repeat (10) @(posedge pclk);
         chk({i_oe, o_oe, p7i, p6i}, {k < 2 & po[3], k == 0 | k == 1 & po[1],
             k < 2 & pin1, k == 1 & pin2});
         if (k < 2) chk(i_out, po[2]);
         if (k == 1) chk(o_out, po[0]);
      end
      $display("test pins done");
      stop_test;
   end
   initial begin
      #(40 * 20000);
      fails++;
      stop_test;
   end
endmodule
